/* File: src/irdc_pkg.sv */
// Constants, types and layouts shared by the internal RAM and register space decoder.
// Assumes one 20 MHz clock and a synchronous active-high reset from the core.
package irdc_pkg;

	// Memory map
	localparam int          IRDC_RAM_BYTES   = 256;
	localparam int          IRDC_RAM_AW      = 8;
	localparam logic [7:0]  IRDC_BANK_BASE   = 8'h00;
	localparam logic [7:0]  IRDC_BIT_BASE    = 8'h20;
	localparam logic [7:0]  IRDC_GEN_BASE    = 8'h30;
	localparam logic [7:0]  IRDC_UPPER_BASE  = 8'h80;
	localparam int          IRDC_EXTENDED_DATA_RAM_BYTES  = 4096;
	localparam int          IRDC_DATA_BYTES  = 65536;
	localparam int          IRDC_FLASH_BYTES = 131072;
	localparam int          IRDC_FLASH_AW    = 17;

	// Status word fields
	localparam int          IRDC_BANK_LSB    = 3;
	localparam int          IRDC_BANK_MSB    = 4;
	localparam int          IRDC_PAR_BIT     = 0;

	// Register file layout
	localparam int          IRDC_SFR_COUNT   = 9;
	localparam int          IDX_STACK   = 0;
	localparam int          IDX_PTR0_LO = 1;
	localparam int          IDX_PTR0_HI = 2;
	localparam int          IDX_PTR1_LO = 3;
	localparam int          IDX_PTR1_HI = 4;
	localparam int          IDX_PTR_SEL = 5;
	localparam int          IDX_STATUS  = 6;
	localparam int          IDX_ARITH   = 7;
	localparam int          IDX_AUX     = 8;
	localparam logic [7:0]  IRDC_SFR_ADDR  [IRDC_SFR_COUNT] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85,
		8'h86, 8'hD0, 8'hE0, 8'hF0};
	localparam logic [7:0]  IRDC_SFR_WMASK [IRDC_SFR_COUNT] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'h01, 8'hDC, 8'hFF, 8'hFF};
	localparam logic [7:0]  IRDC_SFR_RESET [IRDC_SFR_COUNT] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00};

	typedef enum logic [1:0] {
		IRDC_DIRECT,
		IRDC_INDIRECT,
		IRDC_BIT,
		IRDC_BANKREG
	} irdc_mode_t;

	typedef enum logic {
		ST_IDLE,
		ST_FETCH
	} irdc_state_t;

	typedef struct packed {
		irdc_mode_t mode;
		logic       write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} irdc_req_t;

	typedef struct packed {
		logic [7:0] stack_top_pointer;
		logic [7:0] data_ptr0_low;
		logic [7:0] data_ptr0_high;
		logic [7:0] data_ptr1_low;
		logic [7:0] data_ptr1_high;
		logic [7:0] data_ptr_select;
		logic [7:0] program_status_word;
		logic [7:0] main_arith_register;
		logic [7:0] mul_div_aux;
	} irdc_core_regs_t;

endpackage

/* File: src/irdc_ram.sv */
// Single-port scratch RAM with registered read data.
// Assumes the caller may read and write one word in the same cycle; the read returns the old word.
module irdc_ram #(
	parameter int DEPTH = 256,
	parameter int WIDTH = 8,
	parameter int AW    = 8
) (
	// Clock
	input  wire logic             clock,
	// Access
	input  wire logic [AW-1:0]    addr,
	input  wire logic             we,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem_reg [DEPTH];

	if (DEPTH != (1 << AW)) begin : g_bad_depth
		$error("irdc_ram: DEPTH must equal 2**AW");
	end

	// No reset: contents are kept across core reset
	always_ff @(posedge clock) begin
		if (we) begin
			mem_reg[addr] <= wdata;
		end
		rdata <= mem_reg[addr];
	end
endmodule

/* File: src/irdc_sfr_cell.sv */
// One byte of the special function register file with a write mask.
// Assumes writes arrive as single-cycle enables from the decoder.
module irdc_sfr_cell #(
	parameter logic [7:0] WMASK = 8'hFF,
	parameter logic [7:0] RESET = 8'h00
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// Write port
	input  wire logic       we,
	input  wire logic [7:0] wdata,
	output logic      [7:0] q
);
	always_ff @(posedge clock) begin
		if (reset) begin
			q <= RESET;
		end else if (we) begin
			q <= (q & ~WMASK) | (wdata & WMASK);
		end
	end
endmodule

/* File: src/irdc_top.sv */
// Internal RAM and special function register space decoder of the core.
// Assumes the core holds a request until taken and samples the answer on ack_valid.
module irdc_top
	import irdc_pkg::*;
#(
	parameter int EXTENDED_DATA_RAM_BYTES  = IRDC_EXTENDED_DATA_RAM_BYTES,
	parameter int FLASH_BYTES = IRDC_FLASH_BYTES
) (
	// Clock and reset
	input  wire logic                        clock,
	input  wire logic                        reset,
	// Core access request
	input  wire logic                        req_valid,
	input  wire irdc_req_t                   req,
	output logic                             req_ready,
	// Core access answer
	output logic                             ack_valid,
	output logic      [7:0]                  ack_rdata,
	output logic                             ack_bit,
	// Register view for the core
	output irdc_core_regs_t                  core_regs,
	output logic      [1:0]                  bank_sel,
	// Data space decode
	input  wire logic [15:0]                 xaddr,
	output logic                             extended_data_ram_sel,
	output logic                             periph_sel,
	// Program space mapping
	input  wire logic                        code_bank,
	input  wire logic [15:0]                 code_addr,
	output logic      [IRDC_FLASH_AW-1:0]    flash_addr
);
	if (EXTENDED_DATA_RAM_BYTES < 1 || EXTENDED_DATA_RAM_BYTES > IRDC_DATA_BYTES) begin : g_bad_extended_data_ram
		$error("irdc_top: EXTENDED_DATA_RAM_BYTES out of data space");
	end
	if (FLASH_BYTES != (1 << IRDC_FLASH_AW)) begin : g_bad_flash
		$error("irdc_top: FLASH_BYTES must match flash address width");
	end

	irdc_state_t      state_reg;
	irdc_state_t      state_next;
	irdc_req_t        req_reg;
	logic [7:0]       ram_addr_reg;
	logic             is_ram_reg;
	logic [2:0]       bitsel_reg;
	logic [IRDC_SFR_COUNT-1:0] hit_reg;
	logic             ack_valid_reg;
	logic [7:0]       ack_rdata_reg;
	logic             ack_bit_reg;
	logic             extended_data_ram_sel_reg;
	logic [IRDC_FLASH_AW-1:0] flash_addr_reg;

	logic [7:0]       sfr_q  [IRDC_SFR_COUNT];
	logic [7:0]       sfr_rv [IRDC_SFR_COUNT];
	logic [7:0]       rd_chain [IRDC_SFR_COUNT+1];
	logic [IRDC_SFR_COUNT-1:0] hit_vec;
	logic [IRDC_SFR_COUNT-1:0] sfr_we;

	wire              take       = req_valid && (state_reg == ST_IDLE);
	wire              fetch      = (state_reg == ST_FETCH);
	wire [1:0]        bank       = sfr_q[IDX_STATUS][IRDC_BANK_MSB:IRDC_BANK_LSB];
	wire              parity     = ^sfr_q[IDX_ARITH];
	wire              mode_bit   = (req.mode == IRDC_BIT);

	// Region decode of the request
	wire              req_is_ram = (req.mode == IRDC_INDIRECT) || (req.mode == IRDC_BANKREG) ||
		(req.addr < IRDC_UPPER_BASE);
	wire [7:0]        bank_addr  = IRDC_BANK_BASE + {3'h0, bank, req.addr[2:0]};
	wire [7:0]        bit_byte   = req.addr[7] ? {req.addr[7:3], 3'h0} :
		IRDC_BIT_BASE + {4'h0, req.addr[6:3]};
	wire [7:0]        tgt_addr   = (req.mode == IRDC_BANKREG) ? bank_addr :
		mode_bit ? bit_byte : req.addr;

	// Data path of the second cycle
	wire [7:0]        ram_rdata;
	wire [7:0]        src_byte   = is_ram_reg ? ram_rdata : rd_chain[IRDC_SFR_COUNT];
	wire [7:0]        bit_mask   = 8'(8'h01 << bitsel_reg);
	wire [7:0]        merged     = (src_byte & ~bit_mask) | (req_reg.wdata[0] ? bit_mask : 8'h00);
	wire [7:0]        new_byte   = (req_reg.mode == IRDC_BIT) ? merged : req_reg.wdata;
	wire              ram_we     = fetch && is_ram_reg && req_reg.write;
	wire [7:0]        ram_addr   = fetch ? ram_addr_reg : tgt_addr;

	// Scratch RAM, 256 bytes
	irdc_ram #(
		.DEPTH (IRDC_RAM_BYTES),
		.WIDTH (8),
		.AW    (IRDC_RAM_AW)
	) u_ram (
		.clock (clock),
		.addr  (ram_addr),
		.we    (ram_we),
		.wdata (new_byte),
		.rdata (ram_rdata)
	);

	// Register file and read mux
	assign rd_chain[0] = 8'h00;
	for (genvar i = 0; i < IRDC_SFR_COUNT; i++) begin : g_sfr
		assign hit_vec[i] = !req_is_ram && ((mode_bit ? bit_byte : req.addr) == IRDC_SFR_ADDR[i]);
		assign sfr_we[i]  = fetch && hit_reg[i] && req_reg.write;
		assign sfr_rv[i]  = (i == IDX_STATUS) ? {sfr_q[i][7:1], parity} : sfr_q[i];
		assign rd_chain[i+1] = rd_chain[i] | (hit_reg[i] ? sfr_rv[i] : 8'h00);
		irdc_sfr_cell #(
			.WMASK (IRDC_SFR_WMASK[i]),
			.RESET (IRDC_SFR_RESET[i])
		) u_cell (
			.clock (clock),
			.reset (reset),
			.we    (sfr_we[i]),
			.wdata (new_byte),
			.q     (sfr_q[i])
		);
	end

	// Sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (req_valid) begin
					state_next = ST_FETCH;
				end
			end
			ST_FETCH: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			req_reg      <= '0;
			ram_addr_reg <= 8'h00;
			is_ram_reg   <= 1'b0;
			bitsel_reg   <= 3'h0;
			hit_reg      <= '0;
		end else if (take) begin
			req_reg      <= req;
			ram_addr_reg <= tgt_addr;
			is_ram_reg   <= req_is_ram;
			bitsel_reg   <= req.addr[2:0];
			hit_reg      <= hit_vec;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ack_valid_reg <= 1'b0;
			ack_rdata_reg <= 8'h00;
			ack_bit_reg   <= 1'b0;
		end else begin
			ack_valid_reg <= fetch;
			if (fetch) begin
				ack_rdata_reg <= src_byte;
				ack_bit_reg   <= src_byte[bitsel_reg];
			end
		end
	end

	// Data and program space decode
	always_ff @(posedge clock) begin
		if (reset) begin
			extended_data_ram_sel_reg   <= 1'b0;
			flash_addr_reg <= '0;
		end else begin
			extended_data_ram_sel_reg   <= (32'(xaddr) < EXTENDED_DATA_RAM_BYTES);
			flash_addr_reg <= {code_bank, code_addr};
		end
	end

	assign req_ready  = (state_reg == ST_IDLE);
	assign ack_valid  = ack_valid_reg;
	assign ack_rdata  = ack_rdata_reg;
	assign ack_bit    = ack_bit_reg;
	assign extended_data_ram_sel   = extended_data_ram_sel_reg;
	assign periph_sel = !extended_data_ram_sel_reg;
	assign flash_addr = flash_addr_reg;
	assign bank_sel   = bank;
	assign core_regs  = '{stack_top_pointer: sfr_q[IDX_STACK], data_ptr0_low: sfr_q[IDX_PTR0_LO],
		data_ptr0_high: sfr_q[IDX_PTR0_HI], data_ptr1_low: sfr_q[IDX_PTR1_LO],
		data_ptr1_high: sfr_q[IDX_PTR1_HI], data_ptr_select: sfr_q[IDX_PTR_SEL],
		program_status_word: sfr_rv[IDX_STATUS], main_arith_register: sfr_q[IDX_ARITH],
		mul_div_aux: sfr_q[IDX_AUX]};

	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	property p_ack_timing;
		take |=> !req_ready ##1 (ack_valid && req_ready);
	endproperty
	a_ack_timing: assert property (p_ack_timing) else $error("answer not two cycles after request");

	property p_bank_map;
		take && req.mode == IRDC_BANKREG |-> ram_addr[7:5] == 3'h0 && ram_addr[4:3] == bank &&
			ram_addr[2:0] == req.addr[2:0];
	endproperty
	a_bank_map: assert property (p_bank_map) else $error("bank register address wrong");

	property p_bank_reset;
		$past(reset) |-> bank_sel == 2'h0 && core_regs.stack_top_pointer == IRDC_SFR_RESET[IDX_STACK];
	endproperty
	a_bank_reset: assert property (p_bank_reset) else $error("bank not zero after reset");

	property p_bit_map;
		take && mode_bit && !req.addr[7] |-> ram_addr == IRDC_BIT_BASE + {4'h0, req.addr[6:3]} ##1
			(ram_addr == $past(ram_addr) && is_ram_reg);
	endproperty
	a_bit_map: assert property (p_bit_map) else $error("bit address maps to wrong byte");

	property p_direct_sfr;
		take && req.mode == IRDC_DIRECT && req.addr[7] |=> !ram_we && !is_ram_reg;
	endproperty
	a_direct_sfr: assert property (p_direct_sfr) else $error("direct upper access reached RAM");

	property p_indirect;
		take && req.mode == IRDC_INDIRECT && req.write |-> ram_addr == req.addr ##1 ram_we;
	endproperty
	a_indirect: assert property (p_indirect) else $error("indirect write missed RAM");

	property p_direct_low;
		take && req.mode == IRDC_DIRECT && !req.addr[7] && req.write |=> ram_we && ram_addr == $past(req.addr);
	endproperty
	a_direct_low: assert property (p_direct_low) else $error("direct low write missed RAM");

	property p_unmapped;
		fetch && !is_ram_reg && hit_reg == '0 |=> ack_valid && ack_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped register read not zero");

	property p_extended_data_ram;
		(32'(xaddr) < EXTENDED_DATA_RAM_BYTES) |=> extended_data_ram_sel && !periph_sel;
	endproperty
	a_extended_data_ram: assert property (p_extended_data_ram) else $error("extended RAM address not selected");

	property p_extended_data_ram_high;
		(32'(xaddr) >= EXTENDED_DATA_RAM_BYTES) |=> periph_sel && !extended_data_ram_sel;
	endproperty
	a_extended_data_ram_high: assert property (p_extended_data_ram_high) else $error("peripheral address not selected");

	property p_flash_map;
		1'b1 |=> flash_addr == {$past(code_bank), $past(code_addr)};
	endproperty
	a_flash_map: assert property (p_flash_map) else $error("program address not mapped to flash");

	property p_ack_single;
		ack_valid |=> !ack_valid;
	endproperty
	a_ack_single: assert property (p_ack_single) else $error("answer pulse longer than one cycle");

	property p_ack_quiet;
		!fetch |=> !ack_valid;
	endproperty
	a_ack_quiet: assert property (p_ack_quiet) else $error("answer without a taken request");

	property p_read_hold;
		!fetch |=> $stable(ack_rdata) && $stable(ack_bit);
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("answer data changed between answers");

	property p_bank_write;
		fetch && hit_reg[IDX_STATUS] && req_reg.write && req_reg.mode == IRDC_DIRECT |=>
			bank_sel == $past(req_reg.wdata[IRDC_BANK_MSB:IRDC_BANK_LSB]);
	endproperty
	a_bank_write: assert property (p_bank_write) else $error("bank select not taken from status write");

	property p_indirect_ram;
		take && req.mode == IRDC_INDIRECT |=> is_ram_reg && hit_reg == '0;
	endproperty
	a_indirect_ram: assert property (p_indirect_ram) else $error("indirect access reached registers");

	property p_direct_hit;
		take && req.mode == IRDC_DIRECT && req.addr[7] |=> $onehot0(hit_reg);
	endproperty
	a_direct_hit: assert property (p_direct_hit) else $error("direct access hit several registers");

	property p_unmapped_write;
		fetch && !is_ram_reg && hit_reg == '0 |-> sfr_we == '0 && !ram_we;
	endproperty
	a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped register write landed");

	property p_bankreg_ram;
		take && req.mode == IRDC_BANKREG |=> is_ram_reg && ram_addr[7:5] == 3'h0;
	endproperty
	a_bankreg_ram: assert property (p_bankreg_ram) else $error("bank register outside bank area");

	property p_bit_set;
		fetch && req_reg.mode == IRDC_BIT && req_reg.write |-> new_byte[bitsel_reg] == req_reg.wdata[0];
	endproperty
	a_bit_set: assert property (p_bit_set) else $error("bit write value not placed");

	property p_bit_keep;
		fetch && req_reg.mode == IRDC_BIT |-> (new_byte & ~bit_mask) == (src_byte & ~bit_mask);
	endproperty
	a_bit_keep: assert property (p_bit_keep) else $error("bit write disturbed other bits");

	property p_ack_bit;
		fetch |=> ack_bit == ack_rdata[$past(bitsel_reg)];
	endproperty
	a_ack_bit: assert property (p_ack_bit) else $error("answer bit not from addressed position");
endmodule

/* File: tb/irdc_core_model.sv */
// Core-side model issuing direct, indirect, bit and bank register accesses.
// Assumes the decoder's ready, answer pulse and registered read data.
module irdc_core_model
	import irdc_pkg::*;
(
	// Clock
	input  wire logic       clock,
	// Request
	output logic            req_valid,
	output irdc_req_t       req,
	input  wire logic       req_ready,
	// Answer
	input  wire logic       ack_valid,
	input  wire logic [7:0] ack_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	int gap = 0;

	initial begin
		req_valid = 1'b0;
		req = '0;
	end

	// Idle gap, hold until taken, then wait for the answer pulse
	task automatic access(input irdc_mode_t m, input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic rdy;
		int   n;
		repeat (gap + 1) @(posedge clock);
		req_valid <= 1'b1;
		req <= '{mode: m, write: w, addr: a, wdata: d};
		do begin
			@(negedge clock);
			rdy = req_ready;
			@(posedge clock);
		end while (!rdy);
		req_valid <= 1'b0;
		req <= irdc_req_t'(~{m, w, a, d});
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (!ack_valid && n < 4);
		q = ack_valid ? ack_rdata : 8'hXX;
	endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the scratch RAM and register space decoder.
// Assumes the core model in its own file drives the request port.
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top
	import irdc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic            clock = 1'b0;
	logic            reset = 1'b1;
	logic            req_valid, req_ready, ack_valid, ack_bit, extended_data_ram_sel, periph_sel;
	irdc_req_t       req;
	logic [7:0]      ack_rdata, rd;
	irdc_core_regs_t core_regs;
	logic [1:0]      bank_sel;
	logic [15:0]     xaddr = 16'h0000;
	logic [15:0]     code_addr = 16'h0000;
	logic            code_bank = 1'b0;
	logic [16:0]     flash_addr;
	int              miscompares = 0;
	int              n_checks = 0;

	irdc_top dut_u (.clock(clock), .reset(reset), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.ack_valid(ack_valid), .ack_rdata(ack_rdata), .ack_bit(ack_bit), .core_regs(core_regs),
		.bank_sel(bank_sel), .xaddr(xaddr), .extended_data_ram_sel(extended_data_ram_sel), .periph_sel(periph_sel),
		.code_bank(code_bank), .code_addr(code_addr), .flash_addr(flash_addr));
	irdc_core_model core_u (.clock(clock), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.ack_valid(ack_valid), .ack_rdata(ack_rdata));

	initial begin
		forever #25 clock = ~clock;
	end

	task automatic op(irdc_mode_t m, logic w, logic [7:0] a, logic [7:0] d);
		core_u.access(m, w, a, d, rd);
	endtask

	task automatic apply_reset();
		@(posedge clock);
		reset <= 1'b1;
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		`CHK("stack", 8'h07, core_regs.stack_top_pointer)
		`CHK("bank", 2'b00, bank_sel)
		`CHK("ready", 1'b1, req_ready)
	endtask

	task automatic test_lower();
		op(IRDC_DIRECT, 1'b1, 8'h30, 8'hA5);
		op(IRDC_INDIRECT, 1'b0, 8'h30, 8'h00);
		`CHK("ind30", 8'hA5, rd)
		op(IRDC_INDIRECT, 1'b1, 8'h7F, 8'h69);
		op(IRDC_DIRECT, 1'b0, 8'h7F, 8'h00);
		`CHK("dir7F", 8'h69, rd)
	endtask

	task automatic test_upper();
		op(IRDC_DIRECT, 1'b1, 8'hE0, 8'h3C);
		op(IRDC_INDIRECT, 1'b1, 8'hE0, 8'h5A);
		op(IRDC_INDIRECT, 1'b0, 8'hE0, 8'h00);
		`CHK("indE0", 8'h5A, rd)
		op(IRDC_DIRECT, 1'b0, 8'hE0, 8'h00);
		`CHK("dirE0", 8'h3C, rd)
		`CHK("arith", 8'h3C, core_regs.main_arith_register)
	endtask

	task automatic test_regs();
		logic [7:0] addrs[6] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'hF0, 8'h81};
		foreach (addrs[i]) begin
			op(IRDC_DIRECT, 1'b1, addrs[i], 8'(8'hC0 + i));
			op(IRDC_DIRECT, 1'b0, addrs[i], 8'h00);
			`CHK("reg_rw", 8'(8'hC0 + i), rd)
		end
		`CHK("ptr0_high", 8'hC1, core_regs.data_ptr0_high)
		`CHK("aux", 8'hC4, core_regs.mul_div_aux)
		op(IRDC_DIRECT, 1'b1, 8'h86, 8'hFF);
		`CHK("ptr_sel", 8'h01, core_regs.data_ptr_select)
		op(IRDC_DIRECT, 1'b1, 8'hE0, 8'h00);
		op(IRDC_BIT, 1'b1, 8'hE0, 8'h01);
		`CHK("arith_bit", 8'h01, core_regs.main_arith_register)
		op(IRDC_DIRECT, 1'b1, 8'hD0, 8'hFF);
		op(IRDC_DIRECT, 1'b0, 8'hD0, 8'h00);
		`CHK("status", 8'hDD, rd)
		`CHK("bank3", 2'b11, bank_sel)
		op(IRDC_BIT, 1'b0, 8'hD4, 8'h00);
		`CHK("bank_hi_bit", 1'b1, ack_bit)
		op(IRDC_DIRECT, 1'b1, 8'hD0, 8'h00);
		`CHK("parity", 8'h01, core_regs.program_status_word)
	endtask

	task automatic test_banks();
		for (int b = 0; b < 4; b++) begin
			op(IRDC_DIRECT, 1'b1, 8'hD0, 8'(b << 3));
			`CHK("bank_sel", 2'(b), bank_sel)
			op(IRDC_BANKREG, 1'b1, 8'h05, 8'(8'h40 + b));
			op(IRDC_INDIRECT, 1'b0, 8'(b * 8 + 5), 8'h00);
			`CHK("bankreg", 8'(8'h40 + b), rd)
		end
		op(IRDC_DIRECT, 1'b1, 8'hD0, 8'h00);
	endtask

	task automatic test_bits();
		core_u.gap = 3;
		op(IRDC_DIRECT, 1'b1, 8'h21, 8'h00);
		op(IRDC_BIT, 1'b1, 8'h0B, 8'h01);
		op(IRDC_DIRECT, 1'b0, 8'h21, 8'h00);
		`CHK("byte21", 8'h08, rd)
		op(IRDC_DIRECT, 1'b1, 8'h2F, 8'h00);
		op(IRDC_BIT, 1'b1, 8'h7F, 8'h01);
		op(IRDC_BIT, 1'b0, 8'h7F, 8'h00);
		`CHK("bit7F", 1'b1, ack_bit)
		op(IRDC_DIRECT, 1'b0, 8'h2F, 8'h00);
		`CHK("byte2F", 8'h80, rd)
		core_u.gap = 0;
	endtask

	task automatic test_unmapped();
		logic [7:0] addrs[3] = '{8'h80, 8'h87, 8'hD8};
		foreach (addrs[i]) begin
			op(IRDC_INDIRECT, 1'b1, addrs[i], 8'h11);
			op(IRDC_DIRECT, 1'b1, addrs[i], 8'hFF);
			op(IRDC_DIRECT, 1'b0, addrs[i], 8'h00);
			`CHK("unmapped", 8'h00, rd)
			op(IRDC_INDIRECT, 1'b0, addrs[i], 8'h00);
			`CHK("upper_ram", 8'h11, rd)
		end
	endtask

	task automatic test_retain();
		op(IRDC_DIRECT, 1'b1, 8'h55, 8'h77);
		apply_reset();
		op(IRDC_DIRECT, 1'b0, 8'h55, 8'h00);
		`CHK("kept55", 8'h77, rd)
	endtask

	task automatic test_decode();
		@(posedge clock);
		xaddr <= 16'h0FFF;
		code_bank <= 1'b1;
		code_addr <= 16'h1234;
		@(posedge clock);
		@(negedge clock);
		`CHK("extended_data_ram_sel", 1'b1, extended_data_ram_sel)
		`CHK("flash", 17'h11234, flash_addr)
		@(posedge clock);
		xaddr <= 16'h1000;
		@(posedge clock);
		@(negedge clock);
		`CHK("periph_sel", 1'b1, periph_sel)
	endtask

	task automatic test_done();
		$display("Checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#(5000 * 50);
		miscompares++;
		test_done();
	end

	initial begin
		apply_reset();
		test_lower();
		test_upper();
		test_regs();
		test_banks();
		test_bits();
		test_unmapped();
		test_retain();
		test_decode();
		test_done();
	end
endmodule
